// ===== core/bpdc_pkg.sv
/*
  Package for the burst power-down controller: control bit positions,
  reset values, drain timing figures and the sequencer state type.
  Assumes nothing of its surroundings.
*/
package bpdc_pkg;

  // Control word positions (register 01h) for the two power-down bits.
  localparam int unsigned AUTO_PD_BIT   = 2;
  localparam int unsigned FULL_SLEEP_BIT = 3;

  // Reset values of the latched control bits.
  localparam logic AUTO_PD_RST    = 1'b0;
  localparam logic FULL_SLEEP_RST = 1'b0;

  // Chain latency: base pipeline depth in system clocks plus a per-rate term.
  localparam int unsigned CHAIN_BASE_CYC = 32;
  localparam int unsigned CHAIN_TAP_CYC  = 16;
  localparam int unsigned RATE_W         = 6;
  localparam int unsigned CNT_W          = 12;

  // Sequencer states.
  typedef enum logic [2:0] {
    BPDC_RUN,
    BPDC_DRAIN,
    BPDC_GATED,
    BPDC_CLEAR,
    BPDC_SLEEP
  } bpdc_state_t;

endpackage

// ===== core/bpdc_timer_if.sv
/*
  Interface between the sequencer and its drain/clear timer.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface bpdc_timer_if;
  import bpdc_pkg::*;
  logic             load;
  logic [CNT_W-1:0] length;
  logic             done;
  modport ctrl (output load, output length, input done);
  modport tmr  (input load, input length, output done);
endinterface
`default_nettype wire

// ===== core/bpdc_timer.sv
/*
  Down-counting timer. A load pulse starts a count of the given length;
  done is a one-cycle pulse when the count expires.
  Assumes load is synchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module bpdc_timer
  import bpdc_pkg::*;
(
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Link to the sequencer.
  bpdc_timer_if.tmr tmrIf
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             busy;
    logic             done;
  } bpdc_tmr_t;

  bpdc_tmr_t tmr_ff;
  bpdc_tmr_t nxt_tmr;

  // A fresh load restarts the count even while one is running.
  always_comb begin
    nxt_tmr      = tmr_ff;
    nxt_tmr.done = 1'b0;
    if (tmrIf.load) begin
      nxt_tmr.count = tmrIf.length;
      nxt_tmr.busy  = 1'b1;
    end else if (tmr_ff.busy) begin
      if (tmr_ff.count <= CNT_W'(1)) begin
        nxt_tmr.busy = 1'b0;
        nxt_tmr.done = 1'b1;
      end else begin
        nxt_tmr.count = tmr_ff.count - 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tmr_ff <= '0;
    end else begin
      tmr_ff <= nxt_tmr;
    end
  end

  assign tmrIf.done = tmr_ff.done;

endmodule
`default_nettype wire

// ===== core/burst_power_down_control.sv
/*
  Burst power-down sequencer of a quadrature upconverter. Drains the chain
  after each burst, gates the chain clocks, restarts them on a new burst,
  and runs the clear-then-sleep sequence for full sleep.
  Assumes the control word and rate come from a same-clock register file;
  the framing pin is asynchronous and is synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module burst_power_down_control
  import bpdc_pkg::*;
#(
  parameter int unsigned CTRL_W = 8
)(
  // Clock and reset.
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  // Host framing pin, asynchronous.
  input  wire logic              tx_burst_frame,
  // Control word 01h and interpolation rate from the register file.
  input  wire logic [CTRL_W-1:0] ctrlWord,
  input  wire logic [RATE_W-1:0] interpRate,
  // Clear routine trigger from the register file.
  input  wire logic              clearReq,
  // Outputs to the chain and the rest of the device.
  output var  logic              chainClkEn,
  output var  logic              syncClkEn,
  output var  logic              analogEn,
  output var  logic              sampleZero,
  output var  logic              filterHold,
  output var  logic              clearDone,
  output var  logic              sleeping
);

  typedef struct packed {
    logic        frmMeta;
    logic        frmSync;
    logic        frmPrev;
    bpdc_state_t state;
    logic        sleepAfter;
    logic        chainClkEn;
    logic        analogEn;
    logic        sampleZero;
    logic        filterHold;
    logic        clearDone;
    logic        sleeping;
  } bpdc_seq_t;

  bpdc_seq_t seq_ff;
  bpdc_seq_t nxt_seq;
  logic      frameRise;
  logic      frameFall;
  logic      autoEn;
  logic      sleepEn;
  logic [CNT_W-1:0] drainLen;

  bpdc_timer_if tIf ();

  bpdc_timer u_timer (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .tmrIf   (tIf.tmr)
  );

  // Edge detection reads only the second synchroniser stage.
  assign frameRise = seq_ff.frmSync & ~seq_ff.frmPrev;
  assign frameFall = ~seq_ff.frmSync & seq_ff.frmPrev;
  assign autoEn    = ctrlWord[AUTO_PD_BIT];
  assign sleepEn   = ctrlWord[FULL_SLEEP_BIT];
  // Longer interpolation slows the early filters, so latency grows per rate step.
  // The largest rate code gives 1040 cycles, well inside the 12-bit counter.
  assign drainLen  = CNT_W'(CHAIN_BASE_CYC + CHAIN_TAP_CYC * interpRate);

  // Sequencer next state. Register contents live outside and are never touched here.
  always_comb begin
    nxt_seq         = seq_ff;
    nxt_seq.frmMeta = tx_burst_frame;
    nxt_seq.frmSync = seq_ff.frmMeta;
    nxt_seq.frmPrev = seq_ff.frmSync;
    nxt_seq.clearDone = 1'b0;
    tIf.load   = 1'b0;
    tIf.length = drainLen;
    case (seq_ff.state)
      BPDC_RUN: begin
        if (sleepEn || clearReq) begin
          nxt_seq.sleepAfter = sleepEn;
          nxt_seq.state      = BPDC_CLEAR;
          tIf.load           = 1'b1;
        end else if (autoEn && frameFall) begin
          nxt_seq.state = BPDC_DRAIN;
          tIf.load      = 1'b1;
        end
      end
      BPDC_DRAIN: begin
        if (sleepEn) begin
          nxt_seq.sleepAfter = 1'b1;
          nxt_seq.state      = BPDC_CLEAR;
          tIf.load           = 1'b1;
        end else if (frameRise || !autoEn) begin
          // A new burst beats the timer; the clocks never stopped, so there is no restart cost.
          nxt_seq.state = BPDC_RUN;
        end else if (tIf.done) begin
          nxt_seq.state = BPDC_GATED;
        end
      end
      BPDC_GATED: begin
        if (sleepEn) begin
          // Sleep from here still clears first; the timer is reloaded for the clear.
          nxt_seq.sleepAfter = 1'b1;
          nxt_seq.state      = BPDC_CLEAR;
          tIf.load           = 1'b1;
        end else if (seq_ff.frmSync || !autoEn) begin
          nxt_seq.state = BPDC_RUN;
        end
      end
      BPDC_CLEAR: begin
        if (tIf.done) begin
          nxt_seq.clearDone = 1'b1;
          nxt_seq.state     = seq_ff.sleepAfter ? BPDC_SLEEP : BPDC_RUN;
        end
      end
      BPDC_SLEEP: begin
        // Host must then wait for lock before framing again.
        // Analog sections and the sync clock are off; the register file keeps its words, so nothing needs reprogramming.
        if (!sleepEn) begin
          nxt_seq.state      = BPDC_RUN;
          nxt_seq.sleepAfter = 1'b0;
        end
      end
      default: nxt_seq.state = BPDC_RUN;
    endcase
    // Outputs are computed from the next state so they leave flip-flops aligned.
    nxt_seq.chainClkEn = (nxt_seq.state == BPDC_RUN) || (nxt_seq.state == BPDC_DRAIN)
                         || (nxt_seq.state == BPDC_CLEAR);
    nxt_seq.sampleZero = (nxt_seq.state == BPDC_CLEAR);
    nxt_seq.filterHold = (nxt_seq.state == BPDC_CLEAR);
    nxt_seq.sleeping   = (nxt_seq.state == BPDC_SLEEP);
    nxt_seq.analogEn   = (nxt_seq.state != BPDC_SLEEP);
  end

  // State register; everything resets to the running state.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      seq_ff            <= '0;
      seq_ff.state      <= BPDC_RUN;
      seq_ff.chainClkEn <= 1'b1;
      seq_ff.analogEn   <= 1'b1;
    end else begin
      seq_ff <= nxt_seq;
    end
  end

  // Sync clock runs always except in full sleep; gating only hits the chain.
  assign syncClkEn  = seq_ff.analogEn;
  assign chainClkEn = seq_ff.chainClkEn;
  assign analogEn   = seq_ff.analogEn;
  assign sampleZero = seq_ff.sampleZero;
  assign filterHold = seq_ff.filterHold;
  assign clearDone  = seq_ff.clearDone;
  assign sleeping   = seq_ff.sleeping;

  // Checks.
  gate_after_drain_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $fell(chainClkEn) && !sleeping |-> $past(seq_ff.state) == BPDC_DRAIN)
    else $error("Chain clock gated without drain.");
  sync_kept_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    seq_ff.state == BPDC_GATED |-> syncClkEn && analogEn)
    else $error("Sync clock stopped during auto power-down.");
  restart_fast_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    seq_ff.state == BPDC_GATED && seq_ff.frmSync && !sleepEn |=> chainClkEn)
    else $error("Chain clock not restarted on frame.");
  auto_off_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !autoEn && !sleepEn && seq_ff.state == BPDC_RUN |=> seq_ff.state != BPDC_DRAIN)
    else $error("Drain entered with auto power-down disabled.");
  sleep_analog_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sleeping |-> !analogEn && !chainClkEn)
    else $error("Sleep with sections powered.");
  clear_first_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(sleeping) |-> $past(seq_ff.state) == BPDC_CLEAR)
    else $error("Sleep entered without clear.");
  clear_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    seq_ff.state == BPDC_CLEAR |-> sampleZero && filterHold && chainClkEn)
    else $error("Clear without zeroing and filter hold.");
  drain_len_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    seq_ff.state == BPDC_RUN && autoEn && !sleepEn && !clearReq && frameFall
    |=> (seq_ff.state == BPDC_DRAIN) [*2])
    else $error("Drain ended too early.");

  drain_cut_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    seq_ff.state == BPDC_DRAIN && frameRise && !sleepEn |=> seq_ff.state == BPDC_RUN && chainClkEn)
    else $error("New burst did not cut the drain.");
  auto_drop_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (seq_ff.state == BPDC_DRAIN || seq_ff.state == BPDC_GATED) && !autoEn && !sleepEn
    |=> seq_ff.state == BPDC_RUN && chainClkEn)
    else $error("Auto power-down kept after its bit cleared.");
  gated_sleep_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    seq_ff.state == BPDC_GATED && sleepEn |=> seq_ff.state == BPDC_CLEAR && chainClkEn && sampleZero)
    else $error("Sleep from gated state skipped the clear.");
  sleep_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    seq_ff.state == BPDC_SLEEP && sleepEn |=> sleeping && $stable(seq_ff.sleepAfter))
    else $error("Sleep left while the sleep bit is set.");
  wake_up_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    seq_ff.state == BPDC_SLEEP && !sleepEn |=> analogEn && syncClkEn && !sleeping)
    else $error("No wake after the sleep bit cleared.");
  clear_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clearDone |-> $past(seq_ff.state) == BPDC_CLEAR ##1 !clearDone)
    else $error("Clear completion not a single pulse.");

  // Covers: gating, restart, sleep, a stand-alone clear and a drain cut short by a burst.
  drain_seen_c:   cover property (@(posedge clk_sys) seq_ff.state == BPDC_GATED);
  restart_seen_c: cover property (@(posedge clk_sys) $rose(chainClkEn) && !sleeping);
  sleep_seen_c:   cover property (@(posedge clk_sys) $rose(sleeping));
  clear_seen_c:   cover property (@(posedge clk_sys) clearDone && !seq_ff.sleepAfter);
  abort_seen_c:   cover property (@(posedge clk_sys) seq_ff.state == BPDC_DRAIN && frameRise);

endmodule
`default_nettype wire

// ===== verification/bpdc_host_model.sv
/*
  Host-side model of the baseband logic that frames bursts.
  Assumes one system clock; the bench asks for a burst through frameReq.
*/
`timescale 1ns/1ps
`default_nettype none
module bpdc_host_model #(
  parameter int unsigned LOCK_WAIT = 20
)(
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Bench request and device status.
  input  wire logic frameReq,
  input  wire logic sleeping,
  // Framing pin toward the device.
  output var  logic tx_burst_frame
);
  int settleCnt;

  // Framing stays low after sleep until a lock settle time has passed.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      settleCnt      <= 0;
      tx_burst_frame <= 1'b0;
    end else begin
      if (sleeping) settleCnt <= LOCK_WAIT;
      else if (settleCnt != 0) settleCnt <= settleCnt - 1;
      tx_burst_frame <= #1 frameReq && !sleeping && settleCnt == 0;
    end
  end
endmodule
`default_nettype wire

// ===== verification/tb.sv
/*
  Self-checking bench for the burst power-down sequencer.
  Assumes the host model drives the framing pin; the bench drives the rest.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bpdc_pkg::*;
  logic clkSys = 1'b0, rstB = 1'b0, frameReq = 1'b1, clearReq = 1'b0, txFrame;
  logic [7:0] ctrlWord = 8'h04;
  logic [RATE_W-1:0] interpRate = 6'h00;
  logic chainClkEn, syncClkEn, analogEn, sampleZero, filterHold, clearDone, sleeping;
  int err_count = 0, tests_run = 0, cycCnt = 0, n, len;

  bpdc_host_model u_host (.clk_sys(clkSys), .rst_b(rstB), .frameReq(frameReq),
    .sleeping(sleeping), .tx_burst_frame(txFrame));
  burst_power_down_control #(.CTRL_W(8)) u_dut (.clk_sys(clkSys), .rst_b(rstB),
    .tx_burst_frame(txFrame), .ctrlWord(ctrlWord), .interpRate(interpRate),
    .clearReq(clearReq), .chainClkEn(chainClkEn), .syncClkEn(syncClkEn),
    .analogEn(analogEn), .sampleZero(sampleZero), .filterHold(filterHold),
    .clearDone(clearDone), .sleeping(sleeping));

  // Free-running 100 MHz clock and a cycle ceiling against hangs.
  always #5 clkSys = ~clkSys;
  always @(posedge clkSys) begin
    cycCnt++;
    if (cycCnt == 20000) begin
      err_count++;
      $display("ERROR %0t: cycle limit reached", $time);
      wrap_up();
    end
  end

  // Inputs move one nanosecond after the edge so no race with the design.
  task automatic step(input int k = 1);
    repeat (k) @(posedge clkSys);
    #1;
  endtask

  task automatic chk(input bit ok, input string msg);
    tests_run++;
    if (!ok) begin
      err_count++;
      $display("ERROR %0t: %s", $time, msg);
    end
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: sig = chainClkEn;
      1: sig = sleeping;
      2: sig = clearDone;
      default: sig = sampleZero;
    endcase
  endfunction

  // Bounded wait on a selected output; n returns the cycles spent.
  task automatic waitv(input int s, input logic v, input int lim);
    n = 0;
    while (sig(s) !== v && n < lim) begin
      step();
      n++;
    end
  endtask

  task automatic t_drain();
    for (int i = 0; i < 2; i++) begin
      interpRate = (i == 0) ? 6'h00 : 6'h02;
      len = CHAIN_BASE_CYC + CHAIN_TAP_CYC * interpRate;
      frameReq = 1'b1;
      step(6);
      frameReq = 1'b0;
      waitv(0, 1'b0, 700);
      chk(n >= len && n <= len + 8, "drain length wrong");
      chk(syncClkEn === 1'b1 && analogEn === 1'b1, "sync clock stopped");
      step(5);
      chk(syncClkEn === 1'b1 && chainClkEn === 1'b0, "gated state lost");
      frameReq = 1'b1;
      waitv(0, 1'b1, 10);
      chk(n <= 6 && chainClkEn === 1'b1, "restart slow");
    end
    $display("test drain done");
  endtask

  task automatic t_disable();
    interpRate = 6'h00;
    frameReq = 1'b0;
    waitv(0, 1'b0, 700);
    ctrlWord = 8'h00;
    step(2);
    chk(chainClkEn === 1'b1, "still gated with auto off");
    frameReq = 1'b1;
    step(6);
    frameReq = 1'b0;
    step(60);
    chk(chainClkEn === 1'b1, "gated while disabled");
    frameReq = 1'b1;
    ctrlWord = 8'h04;
    step(6);
    $display("test disable done");
  endtask

  task automatic t_clear();
    len = CHAIN_BASE_CYC;
    clearReq = 1'b1;
    step();
    clearReq = 1'b0;
    waitv(3, 1'b1, 4);
    chk(sampleZero === 1'b1 && filterHold === 1'b1, "clear not started");
    waitv(2, 1'b1, 100);
    chk(n >= len - 4 && n <= len + 6, "clear length wrong");
    step(2);
    chk(sampleZero === 1'b0 && filterHold === 1'b0 && clearDone === 1'b0, "clear not released");
    $display("test clear done");
  endtask

  // A burst that returns mid-drain, then sleep requested from the gated state.
  task automatic t_abort();
    len = CHAIN_BASE_CYC;
    frameReq = 1'b0;
    step(10);
    frameReq = 1'b1;
    waitv(0, 1'b0, 60);
    chk(n == 60, "drain not cut by new burst");
    frameReq = 1'b0;
    waitv(0, 1'b0, 700);
    chk(n >= len && n <= len + 8, "drain length wrong");
    ctrlWord = 8'h0c;
    waitv(1, 1'b1, 100);
    chk(n >= len - 4 && n <= len + 6 && analogEn === 1'b0, "sleep from gated state wrong");
    ctrlWord = 8'h04;
    frameReq = 1'b1;
    step(3);
    chk(analogEn === 1'b1 && chainClkEn === 1'b1, "no wake from sleep");
    step(30);
    chk(txFrame === 1'b1, "frame not back after wake");
    $display("test abort done");
  endtask

  task automatic t_sleep();
    len = CHAIN_BASE_CYC;
    ctrlWord = 8'h0c;
    waitv(3, 1'b1, 4);
    chk(filterHold === 1'b1 && analogEn === 1'b1 && sleeping === 1'b0, "no clear before sleep");
    waitv(1, 1'b1, 100);
    chk(n >= len - 4 && n <= len + 6, "sleep entry time wrong");
    chk(analogEn === 1'b0 && syncClkEn === 1'b0, "sections still powered");
    step(10);
    ctrlWord = 8'h04;
    step(3);
    chk(analogEn === 1'b1 && syncClkEn === 1'b1 && chainClkEn === 1'b1, "no wake");
    chk(txFrame === 1'b0, "frame before lock");
    step(30);
    chk(txFrame === 1'b1 && sleeping === 1'b0, "frame not resumed");
    frameReq = 1'b0;
    waitv(0, 1'b0, 700);
    chk(n >= len && n <= len + 8, "auto power-down lost over sleep");
    $display("test sleep done");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    step(2);
    rstB = 1'b1;
    step(4);
    t_drain();
    t_disable();
    t_clear();
    t_abort();
    t_sleep();
    wrap_up();
  end
endmodule
`default_nettype wire
